//--- common/slgc_link_if.sv
// Serial link between serializer and deserializer ends.
// Both ends share one clock; the bench joins the two modports.
`timescale 1ns/1ps
interface slgc_link_if;
    logic [3:0] fwd_gpio;
    logic fwd_valid;
    logic bc_strobe;
    logic [2:0] bc_mode;
    logic [1:0] bc_rate;
    logic [3:0] bc_gpio;
    logic rreq;
    logic rwrite;
    logic [7:0] raddr;
    logic [7:0] rwdata;
    logic rack;
    logic [7:0] rrdata;
    modport ser (output fwd_gpio, fwd_valid, rack, rrdata,
        input bc_strobe, bc_mode, bc_rate, bc_gpio, rreq, rwrite, raddr,
        rwdata);
    modport des (input fwd_gpio, fwd_valid, rack, rrdata,
        output bc_strobe, bc_mode, bc_rate, bc_gpio, rreq, rwrite, raddr,
        rwdata);
endinterface

//--- common/slgc_pkg.sv
// Shared constants for the serial link GPIO configuration ends.
// Assumes both ends run on the same 50 MHz clock.
package slgc_pkg;
    localparam int CLK_NS = 20;
    localparam int AW = 8;
    localparam int DW = 8;
    localparam int FW = 4;
    localparam int NTUN = 4;
    localparam int NLOC = 4;
    // Serializer register offsets
    localparam logic [7:0] OFS_GPIO0 = 8'h0d;
    localparam logic [7:0] OFS_GPIO12 = 8'h0e;
    localparam logic [7:0] OFS_GPIO3 = 8'h0f;
    localparam logic [7:0] OFS_LOC56 = 8'h10;
    localparam logic [7:0] OFS_LOC78 = 8'h11;
    localparam logic [7:0] OFS_IN_LEVELS = 8'h1c;
    localparam logic [7:0] OFS_IN_LEVEL8 = 8'h1d;
    // Deserializer register offsets
    localparam logic [7:0] OFS_D_GPIO0 = 8'h1d;
    localparam logic [7:0] OFS_D_GPIO12 = 8'h1e;
    localparam logic [7:0] OFS_D_GPIO3 = 8'h1f;
    localparam logic [7:0] OFS_D_CHAN = 8'h43;
    localparam logic [7:0] CFG_RESET = 8'h00;
    // Field positions
    localparam int LO = 0;
    localparam int HI = 4;
    localparam int PIN8_BIT = 0;
    localparam int LOC_BASE_BIT = 5;
    // Field codes
    localparam logic [3:0] CODE_OUT_LOW = 4'h1;
    localparam logic [3:0] CODE_OUT_HIGH = 4'h9;
    localparam logic [3:0] CODE_INPUT = 4'h3;
    localparam logic [3:0] CODE_BACK = 4'h5;
    localparam logic [3:0] CODE_FWD = 4'h3;
    // Back-channel GPIO mode codes
    localparam logic [2:0] MODE_NORMAL4 = 3'h0;
    localparam logic [2:0] MODE_FAST4 = 3'h3;
    localparam logic [2:0] MODE_FAST2 = 3'h2;
    localparam logic [2:0] MODE_FAST1 = 3'h1;
    localparam logic [3:0] MASK_ALL = 4'hf;
    localparam logic [3:0] MASK_PAIR = 4'h3;
    localparam logic [3:0] MASK_ONE = 4'h1;
    localparam logic [3:0] MASK_NONE = 4'h0;
    localparam logic [4:0] SPF_NORMAL4 = 5'h01;
    localparam logic [4:0] SPF_FAST4 = 5'h06;
    localparam logic [4:0] SPF_FAST2 = 5'h0a;
    localparam logic [4:0] SPF_FAST1 = 5'h0f;
    // Back-channel frame time per line rate
    localparam int FRAME_NS_5M = 7500;
    localparam int FRAME_NS_10M = 3750;
    localparam int FRAME_NS_20M = 1875;
    localparam int FRAME_CYC_5M = FRAME_NS_5M / CLK_NS;
    localparam int FRAME_CYC_10M = FRAME_NS_10M / CLK_NS;
    localparam int FRAME_CYC_20M = FRAME_NS_20M / CLK_NS;
    localparam logic [1:0] RATE_5M = 2'h0;
    localparam logic [1:0] RATE_10M = 2'h1;
    localparam logic [1:0] RATE_20M = 2'h2;

    function automatic logic [3:0] bc_mask(input logic [2:0] mode);
        case (mode)
            MODE_NORMAL4, MODE_FAST4: bc_mask = MASK_ALL;
            MODE_FAST2: bc_mask = MASK_PAIR;
            MODE_FAST1: bc_mask = MASK_ONE;
            default: bc_mask = MASK_NONE;
        endcase
    endfunction
endpackage

//--- hw/slgc_des.sv
// Deserializer end: pairs tunneled pins, sets back-channel mode and rate,
// and bridges remote register access. Assumes a shared clock with the link.
`timescale 1ns/1ps
module slgc_des (
    input wire logic clock, // System clock
    input wire logic srst, // Synchronous reset
    input wire logic ce, // Clock enable
    slgc_link_if.des link, // Serial link
    input wire logic cfg_we, // Local config write
    input wire logic [7:0] cfg_addr, // Local config address
    input wire logic [7:0] cfg_wdata, // Local config data
    output logic [7:0] cfg_rdata, // Local config readback
    input wire logic back_link_rate_select, // Lower rate choice
    input wire logic back_link_high_rate_control, // Forces top rate
    input wire logic [3:0] pin_i, // Tunneled pin levels
    output logic [3:0] pin_o, // Tunneled pin drive
    output logic [3:0] pin_oe_n, // Low while driving
    input wire logic rem_req, // Remote access request
    input wire logic rem_write, // Remote write
    input wire logic [7:0] rem_addr, // Remote address
    input wire logic [7:0] rem_wdata, // Remote write data
    output logic rem_busy, // Remote access pending
    output logic rem_done, // Remote access done
    output logic [7:0] rem_rdata // Remote read data
);
    logic [7:0] d_gpio0, d_gpio12, d_gpio3, d_chan;
    logic [3:0] sync1, sync2;
    logic [3:0] code [4];
    logic [15:0] cnt, period, frame;
    logic [2:0] mode;
    logic [3:0] bc_sel;

    assign mode = d_chan[2:0];
    assign bc_sel = slgc_pkg::bc_mask(mode);
    assign code[0] = d_gpio0[slgc_pkg::LO +: slgc_pkg::FW];
    assign code[1] = d_gpio12[slgc_pkg::LO +: slgc_pkg::FW];
    assign code[2] = d_gpio12[slgc_pkg::HI +: slgc_pkg::FW];
    assign code[3] = d_gpio3[slgc_pkg::LO +: slgc_pkg::FW];

    always_ff @(posedge clock) begin
        if (srst) begin
            d_gpio0 <= slgc_pkg::CFG_RESET;
            d_gpio12 <= slgc_pkg::CFG_RESET;
            d_gpio3 <= slgc_pkg::CFG_RESET;
            d_chan <= slgc_pkg::CFG_RESET;
            cfg_rdata <= slgc_pkg::CFG_RESET;
        end else if (ce) begin
            if (cfg_we) begin
                case (cfg_addr)
                    slgc_pkg::OFS_D_GPIO0: d_gpio0 <= cfg_wdata;
                    slgc_pkg::OFS_D_GPIO12: d_gpio12 <= cfg_wdata;
                    slgc_pkg::OFS_D_GPIO3: d_gpio3 <= cfg_wdata;
                    slgc_pkg::OFS_D_CHAN: d_chan <= cfg_wdata;
                    default: ;
                endcase
            end
            case (cfg_addr)
                slgc_pkg::OFS_D_GPIO0: cfg_rdata <= d_gpio0;
                slgc_pkg::OFS_D_GPIO12: cfg_rdata <= d_gpio12;
                slgc_pkg::OFS_D_GPIO3: cfg_rdata <= d_gpio3;
                slgc_pkg::OFS_D_CHAN: cfg_rdata <= d_chan;
                default: cfg_rdata <= slgc_pkg::CFG_RESET;
            endcase
        end
    end

    // Pin synchroniser
    always_ff @(posedge clock) begin
        if (srst) begin
            sync1 <= '0;
            sync2 <= '0;
        end else if (ce) begin
            sync1 <= pin_i;
            sync2 <= sync1;
        end
    end

    // Pins in back mode here mirror forward samples from the serializer
    always_ff @(posedge clock) begin
        if (srst) begin
            pin_o <= '0;
            pin_oe_n <= '1;
        end else if (ce) begin
            for (int k = 0; k < slgc_pkg::NTUN; k++) begin
                pin_oe_n[k] <= (code[k] != slgc_pkg::CODE_BACK);
                if (link.fwd_valid && code[k] == slgc_pkg::CODE_BACK) begin
                    pin_o[k] <= link.fwd_gpio[k];
                end
            end
        end
    end

    // Frame length from the chosen line rate
    always_comb begin
        if (back_link_high_rate_control) begin
            frame = 16'(slgc_pkg::FRAME_CYC_20M);
        end else if (back_link_rate_select) begin
            frame = 16'(slgc_pkg::FRAME_CYC_10M);
        end else begin
            frame = 16'(slgc_pkg::FRAME_CYC_5M);
        end
        case (mode)
            slgc_pkg::MODE_FAST4: period = frame / 16'(slgc_pkg::SPF_FAST4);
            slgc_pkg::MODE_FAST2: period = frame / 16'(slgc_pkg::SPF_FAST2);
            slgc_pkg::MODE_FAST1: period = frame / 16'(slgc_pkg::SPF_FAST1);
            default: period = frame / 16'(slgc_pkg::SPF_NORMAL4);
        endcase
    end

    // Back-channel sample strobes
    always_ff @(posedge clock) begin
        if (srst) begin
            cnt <= '0;
            link.bc_strobe <= 1'b0;
            link.bc_mode <= slgc_pkg::MODE_NORMAL4;
            link.bc_rate <= slgc_pkg::RATE_5M;
            link.bc_gpio <= '0;
        end else if (ce) begin
            link.bc_strobe <= 1'b0;
            if (cnt + 16'h0001 >= period) begin
                cnt <= '0;
                link.bc_strobe <= 1'b1;
                link.bc_mode <= mode;
                link.bc_rate <= back_link_high_rate_control ?
                    slgc_pkg::RATE_20M : (back_link_rate_select ?
                    slgc_pkg::RATE_10M : slgc_pkg::RATE_5M);
                for (int k = 0; k < slgc_pkg::NTUN; k++) begin
                    link.bc_gpio[k] <= (code[k] == slgc_pkg::CODE_FWD) &
                        bc_sel[k] & sync2[k];
                end
            end else begin
                cnt <= cnt + 16'h0001;
            end
        end
    end

    // Remote register master over the control path
    always_ff @(posedge clock) begin
        if (srst) begin
            link.rreq <= 1'b0;
            link.rwrite <= 1'b0;
            link.raddr <= '0;
            link.rwdata <= '0;
            rem_done <= 1'b0;
            rem_rdata <= '0;
        end else if (ce) begin
            rem_done <= 1'b0;
            if (link.rreq && link.rack) begin
                link.rreq <= 1'b0;
                rem_done <= 1'b1;
                rem_rdata <= link.rrdata;
            end else if (!link.rreq && rem_req) begin
                link.rreq <= 1'b1;
                link.rwrite <= rem_write;
                link.raddr <= rem_addr;
                link.rwdata <= rem_wdata;
            end
        end
    end
    assign rem_busy = link.rreq;
endmodule

//--- hw/slgc_ser.sv
// Serializer end: tunneled and register-only GPIOs with local and remote
// register access. Assumes the link partner shares this clock.
`timescale 1ns/1ps
module slgc_ser (
    input wire logic clock, // System clock
    input wire logic srst, // Synchronous reset
    input wire logic ce, // Clock enable
    slgc_link_if.ser link, // Serial link
    input wire logic reg_req, // Local register request
    input wire logic reg_write, // Local write
    input wire logic [7:0] reg_addr, // Local address
    input wire logic [7:0] reg_wdata, // Local write data
    output logic reg_ack, // Local access done
    output logic [7:0] reg_rdata, // Local read data
    input wire logic [3:0] gpio_i, // Tunneled pin levels
    output logic [3:0] gpio_o, // Tunneled pin drive
    output logic [3:0] gpio_oe_n, // Low while driving
    input wire logic [3:0] loc_gpio_i, // Pins 5-8 levels
    output logic [3:0] loc_gpio_o, // Pins 5-8 drive
    output logic [3:0] loc_gpio_oe_n, // Low while driving
    output logic [3:0] audio_in, // Audio inputs after override
    output logic [2:0] back_link_mode, // Mode set by far end
    output logic [1:0] back_link_rate // Rate set by far end
);
    logic [7:0] cfg_gpio0, cfg_gpio12, cfg_gpio3, cfg_loc56, cfg_loc78;
    logic [3:0] tsync1, tsync2, lsync1, lsync2;
    logic [3:0] tcode [4];
    logic [3:0] lcode [4];
    logic [3:0] tin, lin, bc_level;
    logic take_rem, acc_go, acc_wr;
    logic [7:0] acc_addr, acc_wdata, rd;
    logic [3:0] bc_sel;

    assign bc_sel = slgc_pkg::bc_mask(link.bc_mode);

    assign tcode[0] = cfg_gpio0[slgc_pkg::LO +: slgc_pkg::FW];
    assign tcode[1] = cfg_gpio12[slgc_pkg::LO +: slgc_pkg::FW];
    assign tcode[2] = cfg_gpio12[slgc_pkg::HI +: slgc_pkg::FW];
    assign tcode[3] = cfg_gpio3[slgc_pkg::LO +: slgc_pkg::FW];
    assign lcode[0] = cfg_loc56[slgc_pkg::LO +: slgc_pkg::FW];
    assign lcode[1] = cfg_loc56[slgc_pkg::HI +: slgc_pkg::FW];
    assign lcode[2] = cfg_loc78[slgc_pkg::LO +: slgc_pkg::FW];
    assign lcode[3] = cfg_loc78[slgc_pkg::HI +: slgc_pkg::FW];

    // Local access wins; remote waits while reg_req is high
    assign take_rem = link.rreq && !link.rack && !reg_req;
    assign acc_go = reg_req || take_rem;
    assign acc_wr = reg_req ? reg_write : link.rwrite;
    assign acc_addr = reg_req ? reg_addr : link.raddr;
    assign acc_wdata = reg_req ? reg_wdata : link.rwdata;

    // Pin synchronisers
    always_ff @(posedge clock) begin
        if (srst) begin
            tsync1 <= '0;
            tsync2 <= '0;
            lsync1 <= '0;
            lsync2 <= '0;
        end else if (ce) begin
            tsync1 <= gpio_i;
            tsync2 <= tsync1;
            lsync1 <= loc_gpio_i;
            lsync2 <= lsync1;
        end
    end

    // Readable levels only in input mode
    always_comb begin
        for (int k = 0; k < slgc_pkg::NTUN; k++) begin
            tin[k] = (tcode[k] == slgc_pkg::CODE_INPUT) & tsync2[k];
            lin[k] = (lcode[k] == slgc_pkg::CODE_INPUT) & lsync2[k];
        end
    end

    // Configuration registers
    always_ff @(posedge clock) begin
        if (srst) begin
            cfg_gpio0 <= slgc_pkg::CFG_RESET;
            cfg_gpio12 <= slgc_pkg::CFG_RESET;
            cfg_gpio3 <= slgc_pkg::CFG_RESET;
            cfg_loc56 <= slgc_pkg::CFG_RESET;
            cfg_loc78 <= slgc_pkg::CFG_RESET;
        end else if (ce && acc_go && acc_wr) begin
            case (acc_addr)
                slgc_pkg::OFS_GPIO0: cfg_gpio0 <= acc_wdata;
                slgc_pkg::OFS_GPIO12: cfg_gpio12 <= acc_wdata;
                slgc_pkg::OFS_GPIO3: cfg_gpio3 <= acc_wdata;
                slgc_pkg::OFS_LOC56: cfg_loc56 <= acc_wdata;
                slgc_pkg::OFS_LOC78: cfg_loc78 <= acc_wdata;
                default: ;
            endcase
        end
    end

    // Read mux
    always_comb begin
        rd = '0;
        case (acc_addr)
            slgc_pkg::OFS_GPIO0: rd = cfg_gpio0;
            slgc_pkg::OFS_GPIO12: rd = cfg_gpio12;
            slgc_pkg::OFS_GPIO3: rd = cfg_gpio3;
            slgc_pkg::OFS_LOC56: rd = cfg_loc56;
            slgc_pkg::OFS_LOC78: rd = cfg_loc78;
            slgc_pkg::OFS_IN_LEVELS: begin
                rd[slgc_pkg::NTUN-1:0] = tin;
                rd[slgc_pkg::LOC_BASE_BIT +: 3] = lin[2:0];
            end
            slgc_pkg::OFS_IN_LEVEL8: rd[slgc_pkg::PIN8_BIT] = lin[3];
            default: rd = '0;
        endcase
    end

    // Access answers, one cycle after the request is taken
    always_ff @(posedge clock) begin
        if (srst) begin
            reg_ack <= 1'b0;
            reg_rdata <= '0;
            link.rack <= 1'b0;
            link.rrdata <= '0;
        end else if (ce) begin
            reg_ack <= reg_req;
            link.rack <= take_rem;
            if (reg_req) begin
                reg_rdata <= rd;
            end
            if (take_rem) begin
                link.rrdata <= rd;
            end
        end
    end

    // Back-channel samples; far end decides mode and rate
    always_ff @(posedge clock) begin
        if (srst) begin
            bc_level <= '0;
            back_link_mode <= slgc_pkg::MODE_NORMAL4;
            back_link_rate <= slgc_pkg::RATE_5M;
        end else if (ce && link.bc_strobe) begin
            back_link_mode <= link.bc_mode;
            back_link_rate <= link.bc_rate;
            for (int k = 0; k < slgc_pkg::NTUN; k++) begin
                if (bc_sel[k]) begin
                    bc_level[k] <= link.bc_gpio[k];
                end
            end
        end
    end

    // Tunneled pin drivers and forward samples
    always_ff @(posedge clock) begin
        if (srst) begin
            gpio_o <= '0;
            gpio_oe_n <= '1;
            link.fwd_gpio <= '0;
            link.fwd_valid <= 1'b0;
        end else if (ce) begin
            link.fwd_valid <= 1'b1;
            for (int k = 0; k < slgc_pkg::NTUN; k++) begin
                link.fwd_gpio[k] <= (tcode[k] == slgc_pkg::CODE_FWD) &
                    tsync2[k];
                case (tcode[k])
                    slgc_pkg::CODE_OUT_LOW: begin
                        gpio_o[k] <= 1'b0;
                        gpio_oe_n[k] <= 1'b0;
                    end
                    slgc_pkg::CODE_OUT_HIGH: begin
                        gpio_o[k] <= 1'b1;
                        gpio_oe_n[k] <= 1'b0;
                    end
                    slgc_pkg::CODE_BACK: begin
                        gpio_o[k] <= bc_level[k];
                        gpio_oe_n[k] <= 1'b0;
                    end
                    default: begin
                        gpio_o[k] <= 1'b0;
                        gpio_oe_n[k] <= 1'b1;
                    end
                endcase
            end
        end
    end

    // Register-only pins stay local and take over shared audio inputs
    always_ff @(posedge clock) begin
        if (srst) begin
            loc_gpio_o <= '0;
            loc_gpio_oe_n <= '1;
            audio_in <= '0;
        end else if (ce) begin
            for (int k = 0; k < slgc_pkg::NLOC; k++) begin
                case (lcode[k])
                    slgc_pkg::CODE_OUT_LOW: begin
                        loc_gpio_o[k] <= 1'b0;
                        loc_gpio_oe_n[k] <= 1'b0;
                        audio_in[k] <= 1'b0;
                    end
                    slgc_pkg::CODE_OUT_HIGH: begin
                        loc_gpio_o[k] <= 1'b1;
                        loc_gpio_oe_n[k] <= 1'b0;
                        audio_in[k] <= 1'b0;
                    end
                    slgc_pkg::CODE_INPUT: begin
                        loc_gpio_o[k] <= 1'b0;
                        loc_gpio_oe_n[k] <= 1'b1;
                        audio_in[k] <= 1'b0;
                    end
                    default: begin
                        loc_gpio_o[k] <= 1'b0;
                        loc_gpio_oe_n[k] <= 1'b1;
                        audio_in[k] <= lsync2[k];
                    end
                endcase
            end
        end
    end
endmodule

//--- testbench/slgc_link_props.sv
// Link checker: remote access handshake and back-channel pacing.
// Assumes one shared clock; placed beside the link interface.
`timescale 1ns/1ps
module slgc_link_props (
    input wire logic clock, // Clock
    input wire logic srst, // Reset
    input wire logic fwd_valid, // Forward valid
    input wire logic bc_strobe, // Sample strobe
    input wire logic [2:0] bc_mode, // Sampling mode
    input wire logic [1:0] bc_rate, // Line rate
    input wire logic [3:0] bc_gpio, // Sampled levels
    input wire logic rreq, // Remote request
    input wire logic rwrite, // Remote write
    input wire logic [7:0] raddr, // Remote address
    input wire logic rack // Remote answer
);
    default clocking dc @(posedge clock);
    endclocking
    default disable iff (srst);
    property p_rack_pulse;
        rack |=> !rack;
    endproperty
    a_rack_pulse: assert property (p_rack_pulse)
        else $error("remote answer held too long");
    property p_rack_cause;
        rack |-> $past(rreq);
    endproperty
    a_rack_cause: assert property (p_rack_cause)
        else $error("remote answer without request");
    property p_rreq_hold;
        rreq && !rack |=> rreq && $stable(raddr) && $stable(rwrite);
    endproperty
    a_rreq_hold: assert property (p_rreq_hold)
        else $error("remote request dropped early");
    property p_rack_bound;
        $rose(rreq) |-> ##[1:16] rack;
    endproperty
    a_rack_bound: assert property (p_rack_bound)
        else $error("remote request not answered");
    property p_fwd_valid;
        fwd_valid |=> fwd_valid;
    endproperty
    a_fwd_valid: assert property (p_fwd_valid)
        else $error("forward valid dropped");
    property p_strobe_gap;
        bc_strobe |=> !bc_strobe [*4];
    endproperty
    a_strobe_gap: assert property (p_strobe_gap)
        else $error("samples too close");
    property p_strobe_due;
        bc_strobe |-> ##[5:800] bc_strobe;
    endproperty
    a_strobe_due: assert property (p_strobe_due)
        else $error("sample strobe missing");
    property p_bc_hold;
        !bc_strobe |-> $stable(bc_gpio) && $stable(bc_mode)
            && $stable(bc_rate);
    endproperty
    a_bc_hold: assert property (p_bc_hold)
        else $error("back-channel fields moved between samples");
endmodule

//--- testbench/test_serial_link_gpio_config.sv
// Bench joining both link ends: registers, pins and back channel.
// Assumes package, link interface and checker are compiled first.
`timescale 1ns/1ps
module test_serial_link_gpio_config;
    logic clock, srst, ce, reg_req, reg_write, reg_ack, cfg_we;
    logic rem_req, rem_write, rem_done, rem_busy, back_link_rate_select;
    logic back_link_high_rate_control;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, cfg_addr, cfg_wdata;
    logic [7:0] rem_addr, rem_wdata, rem_rdata, q, w, cfg_rdata;
    logic [3:0] gpio_i, gpio_o, gpio_oe_n, loc_gpio_i, loc_gpio_o;
    logic [3:0] loc_gpio_oe_n, audio_in, pin_i, pin_o, pin_oe_n, lev;
    logic [2:0] back_link_mode;
    logic [1:0] back_link_rate;
    logic [7:0] mreg[13:17];
    int errors, total_checks;
    int faddr[8] = '{13, 14, 14, 15, 16, 16, 17, 17};
    int fsh[8] = '{0, 0, 4, 0, 0, 4, 0, 4};
    logic [3:0] codes[6] = '{4'h1, 4'h9, 4'h3, 4'h5, 4'h0, 4'h7};
    logic [7:0] rd_list[9] = '{8'h0d, 8'h0e, 8'h0f, 8'h10, 8'h11, 8'h1c,
        8'h1d, 8'h12, 8'h20};
    logic [2:0] modes[4] = '{3'h0, 3'h3, 3'h2, 3'h1};
    logic [3:0] bm[4] = '{4'hf, 4'hf, 4'h3, 4'h1};
    slgc_link_if link_if();
    slgc_ser slgc_ser_inst (.clock, .srst, .ce, .link(link_if), .reg_req,
        .reg_write, .reg_addr, .reg_wdata, .reg_ack, .reg_rdata, .gpio_i,
        .gpio_o, .gpio_oe_n, .loc_gpio_i, .loc_gpio_o, .loc_gpio_oe_n,
        .audio_in, .back_link_mode, .back_link_rate);
    slgc_des slgc_des_inst (.clock, .srst, .ce, .link(link_if), .cfg_we,
        .cfg_addr, .cfg_wdata, .cfg_rdata, .back_link_rate_select,
        .back_link_high_rate_control, .pin_i, .pin_o, .pin_oe_n, .rem_req,
        .rem_write, .rem_addr, .rem_wdata, .rem_busy, .rem_done,
        .rem_rdata);
    slgc_link_props slgc_link_props_inst (.clock, .srst,
        .fwd_valid(link_if.fwd_valid), .bc_strobe(link_if.bc_strobe),
        .bc_mode(link_if.bc_mode), .bc_rate(link_if.bc_rate),
        .bc_gpio(link_if.bc_gpio), .rreq(link_if.rreq),
        .rwrite(link_if.rwrite), .raddr(link_if.raddr), .rack(link_if.rack));
    function automatic logic [3:0] code(int i);
        return 4'(mreg[faddr[i]] >> fsh[i]);
    endfunction
    function automatic logic [3:0] cf(bit b);
        return b ? 4'h3 : 4'h9;
    endfunction
    function automatic logic [7:0] exp_rd(logic [7:0] a);
        logic [7:0] v;
        v = 8'h00;
        if (a >= 8'h0d && a <= 8'h11) v = mreg[a];
        for (int i = 0; i < 8; i++) begin
            if (code(i) == 4'h3) begin
                if (a == 8'h1c && i < 4) v[i] = gpio_i[i];
                if (a == 8'h1c && i inside {[4:6]}) v[i+1] = loc_gpio_i[i-4];
                if (a == 8'h1d && i == 7) v[0] = loc_gpio_i[3];
            end
        end
        return v;
    endfunction
    task automatic chk(string n, logic [7:0] e, logic [7:0] s);
        total_checks++;
        if (s !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wrap_up();
        if (errors == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Local or remote access; reads compared with the model
    task automatic acc(bit rem, bit wr, logic [7:0] a, logic [7:0] d);
        int i;
        if (rem) {rem_req, rem_write, rem_addr, rem_wdata} = {1'b1, wr, a, d};
        else {reg_req, reg_write, reg_addr, reg_wdata} = {1'b1, wr, a, d};
        @(negedge clock);
        if (rem) chk("rem_busy", 8'h01, {7'h0, rem_busy});
        rem_req = 1'b0;
        reg_req = 1'b0;
        for (i = 0; i < 40 && !(rem ? rem_done : reg_ack); i++) begin
            @(negedge clock);
        end
        if (i == 40) begin
            chk("timeout", 8'h01, 8'h00);
            wrap_up();
        end
        q = rem ? rem_rdata : reg_rdata;
        if (wr && a >= 8'h0d && a <= 8'h11) mreg[a] = d;
        if (!wr) chk($sformatf("reg %h", a), exp_rd(a), q);
        @(negedge clock);
    endtask
    task automatic cfg(logic [7:0] a, logic [7:0] d);
        {cfg_we, cfg_addr, cfg_wdata} = {1'b1, a, d};
        @(negedge clock);
        cfg_we = 1'b0;
        @(negedge clock);
        chk("cfg_rdata", d, cfg_rdata);
    endtask
    task automatic chk_pins();
        logic [3:0] c;
        logic [7:0] oe, o, m, u;
        for (int i = 0; i < 8; i++) begin
            c = code(i);
            oe[i] = !(c inside {4'h1, 4'h9} || (c == 4'h5 && i < 4));
            o[i] = (c == 4'h9);
            m[i] = c inside {4'h1, 4'h9};
            u[i] = c inside {4'h1, 4'h9, 4'h3};
        end
        chk("pin_oe_n", oe, {loc_gpio_oe_n, gpio_oe_n});
        chk("pin_o", o & m, {loc_gpio_o, gpio_o} & m);
        chk("audio_in", {4'h0, loc_gpio_i & ~u[7:4]},
            {4'h0, audio_in});
    endtask
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    initial begin
        {errors, total_checks} = '0;
        void'($urandom(32'h63a3));
        {srst, ce} = 2'h3;
        {reg_req, reg_write, reg_addr, reg_wdata, cfg_we, cfg_addr} = '0;
        {cfg_wdata, rem_req, rem_write, rem_addr, rem_wdata} = '0;
        {back_link_rate_select, back_link_high_rate_control} = '0;
        {gpio_i, loc_gpio_i, pin_i, lev} = '0;
        for (int a = 13; a < 18; a++) mreg[a] = 8'h00;
        repeat (2) @(negedge clock);
        srst = 1'b0;
        foreach (rd_list[k]) acc(1'b0, 1'b0, rd_list[k], 8'h00);
        for (int r = 0; r < 6; r++) begin
            {gpio_i, loc_gpio_i} = 8'($urandom);
            for (int k = 0; k < 5; k++) begin
                w = {codes[$urandom_range(5)], codes[$urandom_range(5)]};
                acc(r[0], 1'b1, 8'h0d + 8'(k), w);
            end
            acc(r[0], 1'b1, 8'h1c, 8'hff);
            acc(r[0], 1'b1, 8'h12, 8'h55);
            repeat (4) @(negedge clock);
            chk_pins();
            foreach (rd_list[k]) acc(r[0], 1'b0, rd_list[k], 8'h00);
        end
        cfg(slgc_pkg::OFS_D_GPIO0, 8'h05);
        cfg(slgc_pkg::OFS_D_GPIO12, 8'h55);
        cfg(slgc_pkg::OFS_D_GPIO3, 8'h05);
        for (int r = 0; r < 4; r++) begin
            w = 8'($urandom);
            acc(1'b0, 1'b1, 8'h0d, {4'h0, cf(w[0])});
            acc(1'b0, 1'b1, 8'h0e, {cf(w[2]), cf(w[1])});
            acc(1'b0, 1'b1, 8'h0f, {4'h0, cf(w[3])});
            gpio_i = w[7:4];
            repeat (5) @(negedge clock);
            chk("pin_o", {4'h0, w[7:4] & w[3:0]}, {4'h0, pin_o});
            chk("pin_oe_n", 8'h00, {4'h0, pin_oe_n});
        end
        acc(1'b0, 1'b1, 8'h0d, 8'h05);
        acc(1'b1, 1'b1, 8'h0e, 8'h55);
        acc(1'b0, 1'b1, 8'h0f, 8'h05);
        cfg(slgc_pkg::OFS_D_GPIO0, 8'h03);
        cfg(slgc_pkg::OFS_D_GPIO12, 8'h33);
        cfg(slgc_pkg::OFS_D_GPIO3, 8'h03);
        for (int r = 0; r < 4; r++) begin
            pin_i = 4'($urandom);
            {back_link_high_rate_control, back_link_rate_select} = 2'(r);
            cfg(slgc_pkg::OFS_D_CHAN, {5'h00, modes[r]});
            repeat (800) @(negedge clock);
            lev = (lev & ~bm[r]) | (pin_i & bm[r]);
            chk("mode", {5'h0, modes[r]}, {5'h0, back_link_mode});
            w = {6'h0, r[1] ? 2'h2 : {1'b0, r[0]}};
            chk("rate", w, {6'h0, back_link_rate});
            chk("gpio_o", {4'h0, lev}, {4'h0, gpio_o});
            chk("gpio_oe_n", 8'h00, {4'h0, gpio_oe_n});
        end
        wrap_up();
    end
endmodule
